// ===== verilog/mpcl_top.sv
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/100ps
module mpcl_top #(
	parameter bit HAS_CPU_CLOCK_OUTPUT = 1'b1
) (
	input  wire logic                clk,
	input  wire logic                srst,
	input  wire logic                ext_reset_n,
	input  wire logic [5:0]          avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	input  wire logic [3:0]          avs_byteenable,
	output      logic [31:0]         avs_readdata,
	output      logic                avs_waitrequest,
	input  wire logic [15:0]         cpu_addr,
	input  wire logic                cpu_fetch,
	input  wire logic                external_code_select,
	output      logic                fetch_internal,
	output      logic                fetch_external,
	output      logic                breakpoint_hit_out,
	output      logic                cpu_clock_output_o,
	output      logic                cpu_clock_output_oe,
	input  wire logic                cpu_clock_output_i,
	output      logic [1:0]          cpu_speed,
	input  wire logic                port_a_bit0_i,
	output      logic                port_a_bit0_o,
	output      logic                port_a_bit0_oe,
	input  wire logic                port_a_bit1_i,
	output      logic                port_a_bit1_o,
	output      logic                port_a_bit1_oe,
	output      logic                ext_irq0_req,
	output      logic                ext_irq1_req,
	output      logic                irq
);
	import mpcl_pkg::*;

	// ----------------------------------------------------------------
	// reset: software reset and synchronised chip reset pin
	// ----------------------------------------------------------------
	logic [2:0] rstn_sync_r;
	logic       rst_pin_r;
	logic       rst;

	// the pin level counts only once the second and third stages agree
	always_ff @(posedge clk) begin
		rstn_sync_r <= {rstn_sync_r[1:0], ext_reset_n};
		if (srst)
			rst_pin_r <= 1'b0;
		else if (rstn_sync_r[2] == rstn_sync_r[1])
			rst_pin_r <= ~rstn_sync_r[2];
	end

	assign rst = srst | rst_pin_r;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic        wr_brk_addr, wr_brk_ctrl, wr_cpu_cs, wr_pa_cfg;
	logic        wr_irq_type, wr_port_e, wr_port_a, wr_irq_stat, wr_irq_mask;
	logic        lane0, lane1;
	logic        rd_ack_r;

	assign lane0       = avs_byteenable[0];
	assign lane1       = avs_byteenable[1];
	assign wr_brk_addr = avs_write && avs_address == ADDR_BRK_ADDR;
	assign wr_brk_ctrl = avs_write && lane0 && avs_address == ADDR_BRK_CTRL;
	assign wr_cpu_cs   = avs_write && lane0 && avs_address == ADDR_CPU_CS;
	assign wr_pa_cfg   = avs_write && lane0 && avs_address == ADDR_PA_CFG;
	assign wr_irq_type = avs_write && lane0 && avs_address == ADDR_IRQ_TYPE;
	assign wr_port_e   = avs_write && lane0 && avs_address == ADDR_PORT_E;
	assign wr_port_a   = avs_write && lane0 && avs_address == ADDR_PORT_A;
	assign wr_irq_stat = avs_write && lane0 && avs_address == ADDR_IRQ_STAT;
	assign wr_irq_mask = avs_write && lane0 && avs_address == ADDR_IRQ_MASK;

	// writes complete at once, reads take one wait cycle
	assign avs_waitrequest = avs_read && !rd_ack_r;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [15:0] brk_addr_r;
	logic        brk_en_r, brk_pulse_sel_r, brk_hit_r;
	logic        clk_off_r;
	logic [1:0]  speed_r;
	logic [1:0]  pa_cfg_r, irq_type_r;
	logic [1:0]  pa_out_r, pa_oe_r;
	logic        pe_out_r, pe_oe_r;
	logic [2:0]  stat_r, mask_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			brk_addr_r <= RST_BRK_ADDR;
		end else if (wr_brk_addr) begin
			if (lane0) brk_addr_r[7:0]  <= avs_writedata[7:0];
			if (lane1) brk_addr_r[15:8] <= avs_writedata[15:8];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			brk_en_r        <= 1'b0;
			brk_pulse_sel_r <= 1'b0;
			clk_off_r       <= 1'b0;
			speed_r         <= RST_SPEED;
			pa_cfg_r        <= 2'h0;
			irq_type_r      <= 2'h0;
			pa_out_r        <= 2'h0;
			pa_oe_r         <= 2'h0;
			pe_out_r        <= 1'b0;
			pe_oe_r         <= 1'b0;
			mask_r          <= 3'h0;
		end else begin
			if (wr_brk_ctrl) begin
				brk_en_r        <= avs_writedata[BRK_EN_BIT];
				brk_pulse_sel_r <= avs_writedata[BRK_PULSE_BIT];
			end
			if (wr_cpu_cs) begin
				clk_off_r <= avs_writedata[CS_CLKOFF_BIT];
				if (avs_writedata[CS_SPEED_LSB +: 2] != 2'h3)
					speed_r <= avs_writedata[CS_SPEED_LSB +: 2];
			end
			if (wr_pa_cfg)   pa_cfg_r   <= avs_writedata[1:0];
			if (wr_irq_type) irq_type_r <= avs_writedata[1:0];
			if (wr_port_a) begin
				pa_out_r <= avs_writedata[1:0];
				pa_oe_r  <= avs_writedata[5:4];
			end
			if (wr_port_e) begin
				pe_out_r <= avs_writedata[0];
				pe_oe_r  <= avs_writedata[4];
			end
			if (wr_irq_mask) mask_r <= avs_writedata[2:0];
		end
	end

	// ----------------------------------------------------------------
	// breakpoint
	// ----------------------------------------------------------------
	mpcl_brk_state_type brk_state_r, brk_state_nxt;
	logic [3:0]         brk_cnt_r, brk_cnt_nxt;
	logic               brk_match, hit_clear, brk_event;
	logic               cpu_rise;

	assign brk_match = brk_en_r && cpu_addr == brk_addr_r;
	assign hit_clear = wr_brk_ctrl && avs_writedata[BRK_HIT_BIT];
	assign brk_event = brk_match && brk_state_r == BRK_IDLE;

	always_comb begin
		brk_state_nxt = brk_state_r;
		brk_cnt_nxt   = brk_cnt_r;
		case (brk_state_r)
			BRK_IDLE: begin
				if (brk_match) begin
					brk_state_nxt = brk_pulse_sel_r ? BRK_PULSE : BRK_HOLD;
					brk_cnt_nxt   = 4'(BRK_PULSE_CLKS - 1);
				end
			end
			BRK_PULSE: begin
				// pulse length is counted in periods of the CPU clock
				if (cpu_rise) begin
					if (brk_cnt_r == 4'h0)
						brk_state_nxt = BRK_IDLE;
					else
						brk_cnt_nxt = brk_cnt_r - 4'h1;
				end
			end
			BRK_HOLD: begin
				if (!brk_hit_r)
					brk_state_nxt = BRK_IDLE;
			end
			default: brk_state_nxt = BRK_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			brk_state_r <= BRK_IDLE;
			brk_cnt_r   <= 4'h0;
			brk_hit_r   <= 1'b0;
		end else begin
			brk_state_r <= brk_state_nxt;
			brk_cnt_r   <= brk_cnt_nxt;
			// set wins over clear
			if (brk_event)
				brk_hit_r <= 1'b1;
			else if (hit_clear)
				brk_hit_r <= 1'b0;
		end
	end

	// pulse mode: eight CPU clock periods; hold mode: until hit flag cleared
	always_ff @(posedge clk) begin
		if (rst)
			breakpoint_hit_out <= 1'b0;
		else
			breakpoint_hit_out <= brk_state_nxt != BRK_IDLE;
	end

	// ----------------------------------------------------------------
	// code fetch source
	// ----------------------------------------------------------------
	logic low_range;

	assign low_range      = cpu_addr <= LOW_CODE_TOP;
	assign fetch_internal = cpu_fetch && low_range && !external_code_select;
	assign fetch_external = cpu_fetch && (!low_range || external_code_select);

	// ----------------------------------------------------------------
	// clock output: 48 MHz is the base rate, divided down
	// ----------------------------------------------------------------
	logic [1:0] div_r;
	logic       clk_tick;

	always_ff @(posedge clk) begin
		if (rst) div_r <= 2'h0;
		else     div_r <= div_r + 2'h1;
	end

	always_comb begin
		case (speed_r)
			SPEED_48: clk_tick = 1'b1;
			SPEED_24: clk_tick = div_r[0];
			default:  clk_tick = div_r == 2'h3;
		endcase
	end

	logic clk_out_r;
	always_ff @(posedge clk) begin
		if (rst)           clk_out_r <= 1'b0;
		else if (clk_tick) clk_out_r <= ~clk_out_r;
	end

	// CPU clock rises at the next edge
	assign cpu_rise = clk_tick && !clk_out_r;

	assign cpu_speed           = speed_r;
	assign cpu_clock_output_o  = HAS_CPU_CLOCK_OUTPUT ? clk_out_r : pe_out_r;
	assign cpu_clock_output_oe = HAS_CPU_CLOCK_OUTPUT ? !clk_off_r : pe_oe_r;

	// ----------------------------------------------------------------
	// port A bits 0/1 and external interrupts
	// ----------------------------------------------------------------
	logic [2:0] pa0_sync_r, pa1_sync_r;
	logic [1:0] irq_lvl_r, pin_lvl, irq_req;

	always_ff @(posedge clk) begin
		if (rst) begin
			pa0_sync_r <= 3'h7;
			pa1_sync_r <= 3'h7;
			irq_lvl_r  <= 2'h3;
		end else begin
			pa0_sync_r <= {pa0_sync_r[1:0], port_a_bit0_i};
			pa1_sync_r <= {pa1_sync_r[1:0], port_a_bit1_i};
			irq_lvl_r  <= pin_lvl;
		end
	end

	// a change counts once the second and third stages agree
	assign pin_lvl[0] = (pa0_sync_r[2] == pa0_sync_r[1]) ? pa0_sync_r[2] : irq_lvl_r[0];
	assign pin_lvl[1] = (pa1_sync_r[2] == pa1_sync_r[1]) ? pa1_sync_r[2] : irq_lvl_r[1];

	assign irq_req[0] = pa_cfg_r[0] && (irq_type_r[IRQ0_BIT] ?
		(irq_lvl_r[0] && !pin_lvl[0]) : !pin_lvl[0]);
	assign irq_req[1] = pa_cfg_r[1] && (irq_type_r[IRQ1_BIT] ?
		(irq_lvl_r[1] && !pin_lvl[1]) : !pin_lvl[1]);

	assign ext_irq0_req   = irq_req[0];
	assign ext_irq1_req   = irq_req[1];
	assign port_a_bit0_o  = pa_out_r[0];
	assign port_a_bit0_oe = pa_oe_r[0] && !pa_cfg_r[0];
	assign port_a_bit1_o  = pa_out_r[1];
	assign port_a_bit1_oe = pa_oe_r[1] && !pa_cfg_r[1];

	// ----------------------------------------------------------------
	// interrupt status
	// ----------------------------------------------------------------
	logic [2:0] stat_set, stat_clr;

	assign stat_set = {irq_req[1], irq_req[0], brk_event};
	assign stat_clr = wr_irq_stat ? avs_writedata[2:0] : 3'h0;

	always_ff @(posedge clk) begin
		if (rst) stat_r <= 3'h0;
		else     stat_r <= stat_set | (stat_r & ~stat_clr);
	end

	assign irq = |(stat_r & mask_r);

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	logic [31:0] rd_mux;

	always_comb begin
		case (avs_address)
			ADDR_BRK_ADDR: rd_mux = {16'h0000, brk_addr_r};
			ADDR_BRK_CTRL: rd_mux = {28'h0000000, brk_hit_r, brk_pulse_sel_r, brk_en_r, 1'b0};
			ADDR_CPU_CS:   rd_mux = {27'h0000000, speed_r, 1'b0, clk_off_r, 1'b0};
			ADDR_PA_CFG:   rd_mux = {30'h00000000, pa_cfg_r};
			ADDR_IRQ_TYPE: rd_mux = {30'h00000000, irq_type_r};
			ADDR_PORT_E:   rd_mux = {27'h0000000, pe_oe_r, 3'h0, cpu_clock_output_i};
			ADDR_PORT_A:   rd_mux = {26'h0000000, pa_oe_r, 2'h0, pin_lvl};
			ADDR_IRQ_STAT: rd_mux = {29'h00000000, stat_r};
			ADDR_IRQ_MASK: rd_mux = {29'h00000000, mask_r};
			default:       rd_mux = UNMAPPED_DATA;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_ack_r     <= 1'b0;
			avs_readdata <= 32'h00000000;
		end else begin
			rd_ack_r <= avs_read && !rd_ack_r;
			if (avs_read && !rd_ack_r) avs_readdata <= rd_mux;
		end
	end

endmodule : mpcl_top

// ===== common/mpcl_pkg.sv
package mpcl_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [5:0] ADDR_BRK_ADDR  = 6'h00;
	localparam logic [5:0] ADDR_BRK_CTRL  = 6'h04;
	localparam logic [5:0] ADDR_CPU_CS    = 6'h08;
	localparam logic [5:0] ADDR_PA_CFG    = 6'h0C;
	localparam logic [5:0] ADDR_IRQ_TYPE  = 6'h10;
	localparam logic [5:0] ADDR_PORT_E    = 6'h14;
	localparam logic [5:0] ADDR_PORT_A    = 6'h18;
	localparam logic [5:0] ADDR_IRQ_STAT  = 6'h1C;
	localparam logic [5:0] ADDR_IRQ_MASK  = 6'h20;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BRK_HIT_BIT    = 3;
	localparam int BRK_EN_BIT     = 1;
	localparam int BRK_PULSE_BIT  = 2;
	localparam int CS_CLKOFF_BIT  = 1;
	localparam int CS_SPEED_LSB   = 3;
	localparam int IRQ0_BIT       = 0;
	localparam int IRQ1_BIT       = 1;
	localparam int STAT_BRK_BIT   = 0;
	localparam int STAT_EXT_IRQ0_N_BIT  = 1;
	localparam int STAT_EXT_IRQ1_N_BIT  = 2;

	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic [1:0]  SPEED_12        = 2'h0;
	localparam logic [1:0]  SPEED_24        = 2'h1;
	localparam logic [1:0]  SPEED_48        = 2'h2;
	localparam logic [1:0]  RST_SPEED       = SPEED_12;
	localparam logic [15:0] RST_BRK_ADDR    = 16'h0000;
	localparam logic [15:0] LOW_CODE_TOP    = 16'h3FFF;
	localparam int          BRK_PULSE_CLKS  = 8;
	localparam logic [31:0] UNMAPPED_DATA   = 32'h00000000;

	typedef enum logic [1:0] {
		BRK_IDLE,
		BRK_PULSE,
		BRK_HOLD
	} mpcl_brk_state_type;

endpackage : mpcl_pkg

// ===== testbench/mpcl_top_monitor.sv
`timescale 1ns/100ps
module mpcl_monitor (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic [5:0]  avs_address,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic        avs_waitrequest,
	input wire logic [15:0] cpu_addr,
	input wire logic        cpu_fetch,
	input wire logic        external_code_select,
	input wire logic        fetch_internal,
	input wire logic        fetch_external,
	input wire logic        breakpoint_hit_out,
	input wire logic        cpu_clock_output_oe,
	input wire logic        cpu_clock_output_o,
	input wire logic [1:0]  cpu_speed,
	input wire logic        port_a_bit0_i,
	input wire logic        port_a_bit0_oe,
	input wire logic        ext_irq0_req,
	input wire logic        irq
);
	import mpcl_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
	wire wr_ctrl = wr_ok && avs_address == ADDR_BRK_CTRL;
	wire clr = wr_ctrl && avs_writedata[BRK_HIT_BIT];
	logic pulse_r, cfg0_r, it0_r;
	logic clko_q, out_q;
	logic [3:0] rise_cnt_r;
	// CPU clock rises seen while the breakpoint output has stood high
	always_ff @(posedge clk) begin
		clko_q <= cpu_clock_output_o;
		out_q <= breakpoint_hit_out;
		if (!breakpoint_hit_out || !out_q)
			rise_cnt_r <= 4'h0;
		else if (cpu_clock_output_o && !clko_q)
			rise_cnt_r <= rise_cnt_r + 4'h1;
	end
	// shadow of the mode bits, updated on the same write edge as the design
	always_ff @(posedge clk) begin
		if (srst) begin
			pulse_r <= 1'b0;
			cfg0_r <= 1'b0;
			it0_r <= 1'b0;
		end else begin
			if (wr_ctrl) pulse_r <= avs_writedata[BRK_PULSE_BIT];
			if (wr_ok && avs_address == ADDR_PA_CFG) cfg0_r <= avs_writedata[IRQ0_BIT];
			if (wr_ok && avs_address == ADDR_IRQ_TYPE) it0_r <= avs_writedata[IRQ0_BIT];
		end
	end
	property p_fetch_int;
		cpu_fetch && !external_code_select && cpu_addr <= LOW_CODE_TOP |-> fetch_internal && !fetch_external;
	endproperty
	a_fetch_int: assert property (p_fetch_int) else $error("low fetch not internal");
	property p_fetch_ext;
		cpu_fetch && external_code_select && cpu_addr <= LOW_CODE_TOP |-> fetch_external && !fetch_internal;
	endproperty
	a_fetch_ext: assert property (p_fetch_ext) else $error("low fetch not external");
	property p_pulse;
		$fell(breakpoint_hit_out) && pulse_r |-> $rose(cpu_clock_output_o) && rise_cnt_r == 4'h7;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse length wrong");
	property p_hold;
		breakpoint_hit_out && !pulse_r && !clr && !$past(clr) && !$past(clr, 2) |=> breakpoint_hit_out;
	endproperty
	a_hold: assert property (p_hold) else $error("held output dropped");
	property p_rst;
		disable iff (1'b0) srst |=> !breakpoint_hit_out;
	endproperty
	a_rst: assert property (p_rst) else $error("output high in reset");
	property p_speed_rst;
		$fell(srst) |-> cpu_speed == RST_SPEED;
	endproperty
	a_speed_rst: assert property (p_speed_rst) else $error("speed not default");
	property p_clk_off;
		wr_ok && avs_address == ADDR_CPU_CS && avs_writedata[CS_CLKOFF_BIT] |=> ##[0:1] !cpu_clock_output_oe;
	endproperty
	a_clk_off: assert property (p_clk_off) else $error("clock not released");
	property p_pa_oe;
		cfg0_r |-> !port_a_bit0_oe;
	endproperty
	a_pa_oe: assert property (p_pa_oe) else $error("pin driven in irq mode");
	property p_lvl0;
		(cfg0_r && !it0_r && !port_a_bit0_i)[*4] |-> ext_irq0_req;
	endproperty
	a_lvl0: assert property (p_lvl0) else $error("level request missing");
	property p_edge0;
		cfg0_r && it0_r && ext_irq0_req |=> !ext_irq0_req;
	endproperty
	a_edge0: assert property (p_edge0) else $error("edge request too long");
	c_pulse: cover property ($rose(breakpoint_hit_out) && pulse_r);
	c_irq: cover property ($rose(irq));
	c_edge: cover property (cfg0_r && it0_r && ext_irq0_req);
endmodule : mpcl_monitor
bind mpcl_top mpcl_monitor u_mon (.*);

// ===== testbench/mpcl_pin_model.sv
`timescale 1ns/100ps
// interrupt sources pull low, pins have pull-ups when nobody drives
module mpcl_pin_model (
	input  wire logic pa0_o,
	input  wire logic pa0_oe,
	input  wire logic pa1_o,
	input  wire logic pa1_oe,
	input  wire logic clk_o,
	input  wire logic clk_oe,
	input  wire logic src0_n,
	input  wire logic src1_n,
	output logic      pa0_i,
	output logic      pa1_i,
	output logic      clk_i
);
	assign pa0_i = pa0_oe ? pa0_o : src0_n;
	assign pa1_i = pa1_oe ? pa1_o : src1_n;
	assign clk_i = clk_oe ? clk_o : 1'b1;
endmodule : mpcl_pin_model

// ===== testbench/mpcl_top_bench.sv
`timescale 1ns/100ps
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin err_total++; \
	$display("unexpected %0t got %h exp %h", $time, g, x); end end
module mpcl_top_bench;
	import mpcl_pkg::*;
	typedef struct packed {logic s; logic [15:0] a; logic f; logic i; logic e;} mpcl_row_type;
	localparam mpcl_row_type ROWS [6] = '{{1'b0, 16'h0000, 1'b1, 1'b1, 1'b0},
		{1'b0, 16'h3FFF, 1'b1, 1'b1, 1'b0}, {1'b0, 16'h4000, 1'b1, 1'b0, 1'b1},
		{1'b1, 16'h0000, 1'b1, 1'b0, 1'b1}, {1'b1, 16'h3FFF, 1'b1, 1'b0, 1'b1},
		{1'b0, 16'h0000, 1'b0, 1'b0, 1'b0}};
	logic clk = 1'b0, srst = 1'b1, ext_reset_n = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic cpu_fetch = 1'b0, external_code_select = 1'b0, src0_n = 1'b1, src1_n = 1'b1;
	logic [5:0] avs_address = 6'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, d;
	logic [3:0] avs_byteenable = 4'hF;
	logic [15:0] cpu_addr = 16'h0000;
	logic avs_waitrequest, fetch_internal, fetch_external, breakpoint_hit_out, irq, p;
	logic cpu_clock_output_o, cpu_clock_output_oe, cpu_clock_output_i;
	logic [1:0] cpu_speed;
	logic port_a_bit0_i, port_a_bit0_o, port_a_bit0_oe, port_a_bit1_i, port_a_bit1_o, port_a_bit1_oe;
	logic ext_irq0_req, ext_irq1_req;
	int err_total, compares, cyc, n, m;
	mpcl_top u_dut (.*);
	mpcl_pin_model u_pins (.pa0_o(port_a_bit0_o), .pa0_oe(port_a_bit0_oe), .pa1_o(port_a_bit1_o),
		.pa1_oe(port_a_bit1_oe), .clk_o(cpu_clock_output_o), .clk_oe(cpu_clock_output_oe),
		.src0_n(src0_n), .src1_n(src1_n), .pa0_i(port_a_bit0_i), .pa1_i(port_a_bit1_i),
		.clk_i(cpu_clock_output_i));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic give_verdict;
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : give_verdict
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			give_verdict;
		end
	end
	task automatic wr(input logic [5:0] a, input logic [31:0] v);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= v;
		avs_write <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [5:0] a, output logic [31:0] v);
		@(posedge clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		v = avs_readdata;
		avs_read <= 1'b0;
	endtask : rd
	task automatic hit(input logic [15:0] a);
		@(posedge clk);
		cpu_addr <= a;
		@(posedge clk);
		cpu_addr <= 16'h0000;
	endtask : hit
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		`CHK(breakpoint_hit_out, 1'b0)
		`CHK(cpu_speed, RST_SPEED)
		foreach (ROWS[i]) begin
			@(posedge clk);
			external_code_select <= ROWS[i].s;
			cpu_addr <= ROWS[i].a;
			cpu_fetch <= ROWS[i].f;
			@(negedge clk);
			`CHK(fetch_internal, ROWS[i].i)
			`CHK(fetch_external, ROWS[i].e)
		end
		rd(6'h3C, d);
		`CHK(d, UNMAPPED_DATA)
		wr(ADDR_BRK_ADDR, 32'h0000A55A);
		rd(ADDR_BRK_ADDR, d);
		`CHK(d, 32'h0000A55A)
		wr(ADDR_BRK_CTRL, 32'h06);
		hit(16'hA55B);
		@(negedge clk);
		`CHK(breakpoint_hit_out, 1'b0)
		hit(16'hA55A);
		n = 0;
		repeat (80) begin
			@(negedge clk);
			n += breakpoint_hit_out;
		end
		`CHK((n >= 57 && n <= 64), 1'b1)
		`CHK(irq, 1'b0)
		wr(ADDR_IRQ_MASK, 32'h01);
		@(negedge clk);
		`CHK(irq, 1'b1)
		wr(ADDR_IRQ_STAT, 32'h01);
		repeat (2) @(negedge clk);
		`CHK(irq, 1'b0)
		wr(ADDR_BRK_CTRL, 32'h0A);
		hit(16'hA55A);
		repeat (12) @(negedge clk);
		`CHK(breakpoint_hit_out, 1'b1)
		wr(ADDR_BRK_CTRL, 32'h02);
		@(negedge clk);
		`CHK(breakpoint_hit_out, 1'b1)
		wr(ADDR_BRK_CTRL, 32'h0A);
		repeat (3) @(negedge clk);
		`CHK(breakpoint_hit_out, 1'b0)
		for (int k = 0; k < 3; k++) begin
			wr(ADDR_CPU_CS, 32'(k) << CS_SPEED_LSB);
			repeat (10) @(negedge clk);
			p = cpu_clock_output_o;
			n = 0;
			repeat (40) begin
				@(negedge clk);
				n += int'(cpu_clock_output_o && !p);
				p = cpu_clock_output_o;
			end
			`CHK(n, 5 << k)
		end
		wr(ADDR_CPU_CS, 32'h02);
		repeat (2) @(negedge clk);
		`CHK(cpu_clock_output_oe, 1'b0)
		wr(ADDR_CPU_CS, 32'h00);
		repeat (2) @(negedge clk);
		`CHK(cpu_clock_output_oe, 1'b1)
		wr(ADDR_PORT_A, 32'h30);
		@(negedge clk);
		`CHK({port_a_bit1_oe, port_a_bit0_oe}, 2'h3)
		wr(ADDR_PA_CFG, 32'h03);
		@(negedge clk);
		`CHK({port_a_bit1_oe, port_a_bit0_oe}, 2'h0)
		wr(ADDR_IRQ_TYPE, 32'h00);
		@(posedge clk);
		src0_n <= 1'b0;
		src1_n <= 1'b0;
		repeat (6) @(negedge clk);
		`CHK({ext_irq1_req, ext_irq0_req}, 2'h3)
		@(posedge clk);
		src0_n <= 1'b1;
		src1_n <= 1'b1;
		repeat (6) @(negedge clk);
		`CHK({ext_irq1_req, ext_irq0_req}, 2'h0)
		wr(ADDR_IRQ_TYPE, 32'h03);
		@(posedge clk);
		src0_n <= 1'b0;
		src1_n <= 1'b0;
		n = 0;
		m = 0;
		repeat (12) begin
			@(negedge clk);
			n += ext_irq0_req;
			m += ext_irq1_req;
		end
		`CHK(n, 1)
		`CHK(m, 1)
		wr(ADDR_CPU_CS, 32'h10);
		@(negedge clk);
		`CHK(cpu_speed, SPEED_48)
		@(posedge clk);
		ext_reset_n <= 1'b0;
		repeat (6) @(posedge clk);
		ext_reset_n <= 1'b1;
		repeat (6) @(negedge clk);
		`CHK(cpu_speed, RST_SPEED)
		give_verdict;
	end
endmodule : mpcl_top_bench
